//--- vrfs_pkg.sv
// constants and types for the fault, warning, lock, soft-start and overcurrent register group
package vrfs_pkg;
    localparam logic [7:0] ADDR_WARN_LIMIT = 8'h20;
    localparam logic [7:0] ADDR_FAULT_MASK = 8'h22;
    localparam logic [7:0] ADDR_FAULT_STAT = 8'h23;
    localparam logic [7:0] ADDR_WARN_STAT  = 8'h24;
    localparam logic [7:0] ADDR_OUTPUT_CURRENT_MONITOR       = 8'h26;
    localparam logic [7:0] ADDR_LOCK       = 8'h2a;
    localparam logic [7:0] ADDR_SS_STAT    = 8'h2b;
    localparam logic [7:0] ADDR_OCP_STAT   = 8'h2d;
    localparam logic [7:0] ADDR_OCP_CFG    = 8'h2e;
    localparam logic [7:0] ADDR_SECF_A     = 8'h46;
    localparam logic [7:0] ADDR_SECF_B     = 8'h47;
    localparam logic [7:0] RST_WARN_LIMIT  = 8'hff;
    localparam logic [7:0] RST_ZERO        = 8'h00;
    // fault status / mask bit positions
    localparam int BIT_LIM_A   = 4;
    localparam int BIT_LIM_B   = 3;
    localparam int BIT_PHASE   = 2;
    localparam int BIT_OV      = 1;
    localparam int BIT_UV      = 0;
    localparam int FAULT_W     = 5;
    localparam int BIT_WARN    = 0;
    localparam int BIT_LOCK    = 0;
    localparam int BIT_SECF_OC = 0;
    localparam int SS_W        = 4;
    localparam int OCP_W       = 4;
    typedef struct packed {
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vrfs_req_s;
endpackage

//--- vrfs_regs.sv
// register group: sticky faults, current warning, lock, strap-latched soft-start and overcurrent codes
// Functional notes
// - both output-current limit flags set on limit excursion unless masked
// - phase limit flag set when phase sense exceeds per-phase setting unless masked
// - overvoltage event sets fault bit 1 unless masked
// - undervoltage event sets fault bit 0 unless masked
// - warning bit 0 set when current reading exceeds threshold at 0x20
// - warning bit sticky; only a power-on input toggle clears it
// - current reading is an 8-bit converter value, 0xff at full scale
// - writing lock bit makes lockable registers read-only until reset
// - soft-start strap code stored in bits 3:0 on power-on rising edge
// - all strap settings refresh on every rising edge of power-on input
// - soft-start code picks ramp time, 0000 shortest to 1111 longest
// - phase-7 strap gives overcurrent threshold and delay on power-on rise
// - override config applies only when both second-function enable bits set
// - override sets limit and delay fields independently
// - bits 3:2 select per-phase limit 65/75/100/134 mV
// - bits 1:0 select latch-off delay 4/6/8/10 ms
// - each set mask bit suppresses its same-position fault flag
// - current above threshold also raises the alert output
`timescale 1ns/1ps
module vrfs_regs (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic                    clk_link,
    input  wire logic                    rstLink,
    input  wire logic                    linkReq,
    input  wire vrfs_pkg::vrfs_req_s     linkCmd,
    output logic                         linkAck,
    output logic                         linkBusy,
    output logic [7:0]                   linkRdata,
    input  wire logic                    powerOnPin,
    input  wire logic                    outputLimitFlagA,
    input  wire logic                    outputLimitFlagB,
    input  wire logic                    phaseLimitPin,
    input  wire logic                    overvoltageFlag,
    input  wire logic                    undervoltageFlag,
    input  wire logic                    adcValid,
    input  wire logic [7:0]              adcData,
    input  wire logic [vrfs_pkg::SS_W-1:0]  ssStrapCode,
    input  wire logic [vrfs_pkg::OCP_W-1:0] ocpStrapCode,
    output logic                         alertOut,
    output logic                         lockActive,
    output logic [vrfs_pkg::SS_W-1:0]    softStartCode,
    output logic [1:0]                   ocpLimitSel,
    output logic [1:0]                   ocpDelaySel
);
    localparam int NPIN = 6;

    // ---------------- link domain ----------------
    vrfs_pkg::vrfs_req_s linkHold_q;
    logic                reqTog_q;
    logic [1:0]          ackSync_q;
    logic                ackSeen_q;
    logic                ackTog_q;
    logic [7:0]          rdata_q;

    // request is held stable until its answer returns, so the sys side may sample it freely
    always_ff @(posedge clk_link) begin
        if (rstLink) begin
            reqTog_q   <= 1'b0;
            linkHold_q <= '0;
            linkBusy   <= 1'b0;
        end else if (linkReq && !linkBusy) begin
            reqTog_q   <= ~reqTog_q;
            linkHold_q <= linkCmd;
            linkBusy   <= 1'b1;
        end else if (linkAck) begin
            linkBusy   <= 1'b0;
        end
    end

    always_ff @(posedge clk_link) begin
        if (rstLink) begin
            ackSync_q <= 2'b00;
            ackSeen_q <= 1'b0;
            linkAck   <= 1'b0;
            linkRdata <= 8'h00;
        end else begin
            ackSync_q <= {ackSync_q[0], ackTog_q};
            ackSeen_q <= ackSync_q[1];
            linkAck   <= ackSync_q[1] ^ ackSeen_q;
            if (ackSync_q[1] ^ ackSeen_q) begin
                linkRdata <= rdata_q;
            end
        end
    end

    // ---------------- system domain ----------------
    logic [1:0]      reqSync_q;
    logic            reqSeen_q;
    logic [NPIN-1:0] pinMeta_q;
    logic [NPIN-1:0] pinSync_q;
    logic            enPrev_q;
    logic            doAccess;
    logic            doWrite;
    logic            enRise;
    logic            enToggle;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
            enPrev_q  <= 1'b0;
            reqSync_q <= 2'b00;
            reqSeen_q <= 1'b0;
        end else begin
            pinMeta_q <= {powerOnPin, outputLimitFlagA, outputLimitFlagB,
                          phaseLimitPin, overvoltageFlag, undervoltageFlag};
            pinSync_q <= pinMeta_q;
            enPrev_q  <= pinSync_q[5];
            reqSync_q <= {reqSync_q[0], reqTog_q};
            reqSeen_q <= reqSync_q[1];
        end
    end

    assign enRise   = pinSync_q[5] && !enPrev_q;
    assign enToggle = pinSync_q[5] ^ enPrev_q;
    assign doAccess = reqSync_q[1] ^ reqSeen_q;
    assign doWrite  = doAccess && linkHold_q.write;

    logic [7:0]               warnLimit_q;
    logic [vrfs_pkg::FAULT_W-1:0] faultMask_q;
    logic [vrfs_pkg::FAULT_W-1:0] faultStat_q;
    logic                     warn_q;
    logic [7:0]               output_current_monitor_q;
    logic [vrfs_pkg::SS_W-1:0]  ssCode_q;
    logic [vrfs_pkg::OCP_W-1:0] ocpStrap_q;
    logic [vrfs_pkg::OCP_W-1:0] ocpCfg_q;
    logic                     secfA_q;
    logic                     secfB_q;
    logic                     lockable;
    logic [vrfs_pkg::FAULT_W-1:0] faultRaw;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
        return a == want;
    endfunction

    // writes to the limit registers are shut out until reset once the lock bit is set
    assign lockable = !lockActive;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lockActive <= 1'b0;
        end else if (doWrite && hit(linkHold_q.addr, vrfs_pkg::ADDR_LOCK)
                     && linkHold_q.wdata[vrfs_pkg::BIT_LOCK]) begin
            lockActive <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            warnLimit_q <= vrfs_pkg::RST_WARN_LIMIT;
            faultMask_q <= '0;
            ocpCfg_q    <= '0;
            secfA_q     <= 1'b0;
            secfB_q     <= 1'b0;
        end else if (doWrite && lockable) begin
            if (hit(linkHold_q.addr, vrfs_pkg::ADDR_WARN_LIMIT)) begin
                warnLimit_q <= linkHold_q.wdata;
            end
            if (hit(linkHold_q.addr, vrfs_pkg::ADDR_FAULT_MASK)) begin
                faultMask_q <= linkHold_q.wdata[vrfs_pkg::FAULT_W-1:0];
            end
            if (hit(linkHold_q.addr, vrfs_pkg::ADDR_OCP_CFG)) begin
                ocpCfg_q <= linkHold_q.wdata[vrfs_pkg::OCP_W-1:0];
            end
            if (hit(linkHold_q.addr, vrfs_pkg::ADDR_SECF_A)) begin
                secfA_q <= linkHold_q.wdata[vrfs_pkg::BIT_SECF_OC];
            end
            if (hit(linkHold_q.addr, vrfs_pkg::ADDR_SECF_B)) begin
                secfB_q <= linkHold_q.wdata[vrfs_pkg::BIT_SECF_OC];
            end
        end
    end

    // order follows the status layout: limit A, limit B, phase, over, under
    assign faultRaw = pinSync_q[4:0];

    // a fresh event in the clearing cycle still sets its flag
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            faultStat_q <= '0;
        end else begin
            faultStat_q <= (enRise ? '0 : faultStat_q)
                           | (faultRaw & ~faultMask_q);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            output_current_monitor_q <= 8'h00;
        end else if (adcValid) begin
            output_current_monitor_q <= adcData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            warn_q   <= 1'b0;
            alertOut <= 1'b0;
        end else begin
            warn_q   <= (warn_q && !enToggle) || (output_current_monitor_q > warnLimit_q);
            alertOut <= (warn_q && !enToggle) || (output_current_monitor_q > warnLimit_q);
        end
    end

    // strap codes are converter results on this clock; caught on every power-on rise
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ssCode_q   <= '0;
            ocpStrap_q <= '0;
        end else if (enRise) begin
            ssCode_q   <= ssStrapCode;
            ocpStrap_q <= ocpStrapCode;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            softStartCode <= '0;
            ocpLimitSel   <= 2'b00;
            ocpDelaySel   <= 2'b00;
        end else begin
            softStartCode <= ssCode_q;
            if (secfA_q && secfB_q) begin
                ocpLimitSel <= ocpCfg_q[3:2];
                ocpDelaySel <= ocpCfg_q[1:0];
            end else begin
                ocpLimitSel <= ocpStrap_q[3:2];
                ocpDelaySel <= ocpStrap_q[1:0];
            end
        end
    end

    function automatic logic [7:0] readMux(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            vrfs_pkg::ADDR_WARN_LIMIT: v = warnLimit_q;
            vrfs_pkg::ADDR_FAULT_MASK: v = {3'h0, faultMask_q};
            vrfs_pkg::ADDR_FAULT_STAT: v = {3'h0, faultStat_q};
            vrfs_pkg::ADDR_WARN_STAT:  v = {7'h00, warn_q};
            vrfs_pkg::ADDR_OUTPUT_CURRENT_MONITOR:       v = output_current_monitor_q;
            vrfs_pkg::ADDR_LOCK:       v = {7'h00, lockActive};
            vrfs_pkg::ADDR_SS_STAT:    v = {4'h0, ssCode_q};
            vrfs_pkg::ADDR_OCP_STAT:   v = {4'h0, ocpStrap_q};
            vrfs_pkg::ADDR_OCP_CFG:    v = {4'h0, ocpCfg_q};
            vrfs_pkg::ADDR_SECF_A:     v = {7'h00, secfA_q};
            vrfs_pkg::ADDR_SECF_B:     v = {7'h00, secfB_q};
            default:                   v = 8'h00;
        endcase
        return v;
    endfunction

    // read data loads on the same edge that flips the answer toggle and holds while it crosses, so the link side sees it stable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_q  <= 8'h00;
            ackTog_q <= 1'b0;
        end else if (doAccess) begin
            rdata_q  <= readMux(linkHold_q.addr);
            ackTog_q <= ~ackTog_q;
        end
    end

    // ---------------- checks ----------------
    a_fault_mask_gate: assert property (@(posedge clk_sys) disable iff (rst)
        faultMask_q[vrfs_pkg::BIT_OV] && !faultStat_q[vrfs_pkg::BIT_OV] |=> !faultStat_q[vrfs_pkg::BIT_OV])
        else $error("masked overvoltage flag was set");

    // every flag records its own event unless masked; a masked flag that is clear stays clear
    a_lim_a_sets: assert property (@(posedge clk_sys) disable iff (rst)
        faultRaw[vrfs_pkg::BIT_LIM_A] && !faultMask_q[vrfs_pkg::BIT_LIM_A] |=> faultStat_q[vrfs_pkg::BIT_LIM_A])
        else $error("first limit event not recorded");
    a_lim_b_sets: assert property (@(posedge clk_sys) disable iff (rst)
        faultRaw[vrfs_pkg::BIT_LIM_B] && !faultMask_q[vrfs_pkg::BIT_LIM_B] |=> faultStat_q[vrfs_pkg::BIT_LIM_B])
        else $error("second limit event not recorded");
    a_phase_sets: assert property (@(posedge clk_sys) disable iff (rst)
        faultRaw[vrfs_pkg::BIT_PHASE] && !faultMask_q[vrfs_pkg::BIT_PHASE] |=> faultStat_q[vrfs_pkg::BIT_PHASE])
        else $error("phase limit event not recorded");
    a_ov_sets: assert property (@(posedge clk_sys) disable iff (rst)
        faultRaw[vrfs_pkg::BIT_OV] && !faultMask_q[vrfs_pkg::BIT_OV] |=> faultStat_q[vrfs_pkg::BIT_OV])
        else $error("overvoltage event not recorded");
    a_mask_lim_a: assert property (@(posedge clk_sys) disable iff (rst)
        faultMask_q[vrfs_pkg::BIT_LIM_A] && !faultStat_q[vrfs_pkg::BIT_LIM_A] |=> !faultStat_q[vrfs_pkg::BIT_LIM_A])
        else $error("masked first limit flag was set");
    a_mask_lim_b: assert property (@(posedge clk_sys) disable iff (rst)
        faultMask_q[vrfs_pkg::BIT_LIM_B] && !faultStat_q[vrfs_pkg::BIT_LIM_B] |=> !faultStat_q[vrfs_pkg::BIT_LIM_B])
        else $error("masked second limit flag was set");
    a_mask_phase: assert property (@(posedge clk_sys) disable iff (rst)
        faultMask_q[vrfs_pkg::BIT_PHASE] && !faultStat_q[vrfs_pkg::BIT_PHASE] |=> !faultStat_q[vrfs_pkg::BIT_PHASE])
        else $error("masked phase flag was set");
    a_mask_uv: assert property (@(posedge clk_sys) disable iff (rst)
        faultMask_q[vrfs_pkg::BIT_UV] && !faultStat_q[vrfs_pkg::BIT_UV] |=> !faultStat_q[vrfs_pkg::BIT_UV])
        else $error("masked undervoltage flag was set");
    a_fault_sets: assert property (@(posedge clk_sys) disable iff (rst)
        faultRaw[vrfs_pkg::BIT_UV] && !faultMask_q[vrfs_pkg::BIT_UV] |=> faultStat_q[vrfs_pkg::BIT_UV])
        else $error("undervoltage event not recorded");
    a_fault_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        faultStat_q[vrfs_pkg::BIT_LIM_A] && !enRise |=> faultStat_q[vrfs_pkg::BIT_LIM_A])
        else $error("limit flag dropped without power-on rise");
    a_warn_sets: assert property (@(posedge clk_sys) disable iff (rst)
        output_current_monitor_q > warnLimit_q |=> warn_q && alertOut)
        else $error("warning or alert missed over threshold");
    a_warn_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        warn_q && !enToggle |=> warn_q)
        else $error("warning cleared without toggle");

    // a power-on edge drops the warning only while the reading is not above the limit
    sequence s_toggle_quiet;
        enToggle ##0 !(output_current_monitor_q > warnLimit_q);
    endsequence
    a_warn_clear: assert property (@(posedge clk_sys) disable iff (rst)
        s_toggle_quiet |=> !warn_q && !alertOut)
        else $error("warning survived a power-on toggle");
    a_output_current_monitor_load: assert property (@(posedge clk_sys) disable iff (rst)
        adcValid |=> output_current_monitor_q == $past(adcData))
        else $error("current reading not loaded");
    a_output_current_monitor_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !adcValid |=> $stable(output_current_monitor_q))
        else $error("current reading changed without a conversion");
    a_lock_holds: assert property (@(posedge clk_sys) disable iff (rst)
        lockActive |=> lockActive && $stable(warnLimit_q) && $stable(ocpCfg_q))
        else $error("locked register changed");

    // only a write of one sets the lock; the mask and enable registers freeze with it
    sequence s_lock_write;
        doWrite ##0 hit(linkHold_q.addr, vrfs_pkg::ADDR_LOCK) ##0 linkHold_q.wdata[vrfs_pkg::BIT_LOCK];
    endsequence
    a_lock_sets: assert property (@(posedge clk_sys) disable iff (rst)
        s_lock_write |=> lockActive)
        else $error("lock write did not take");
    a_lock_masked: assert property (@(posedge clk_sys) disable iff (rst)
        lockActive |=> $stable(faultMask_q) && $stable(secfA_q) && $stable(secfB_q))
        else $error("locked mask or enable register changed");
    sequence s_rise;
        !enPrev_q ##0 pinSync_q[5];
    endsequence
    a_strap_latch: assert property (@(posedge clk_sys) disable iff (rst)
        s_rise |=> ssCode_q == $past(ssStrapCode) && ocpStrap_q == $past(ocpStrapCode))
        else $error("strap code not refreshed on power-on rise");
    a_ocp_source: assert property (@(posedge clk_sys) disable iff (rst)
        secfA_q && secfB_q |=> ocpLimitSel == $past(ocpCfg_q[3:2]) && ocpDelaySel == $past(ocpCfg_q[1:0]))
        else $error("override not applied");
    a_ocp_strap: assert property (@(posedge clk_sys) disable iff (rst)
        !(secfA_q && secfB_q) |=> ocpLimitSel == $past(ocpStrap_q[3:2]))
        else $error("strap threshold not used");

    // strap codes move only on a power-on rise; the outputs follow one cycle behind
    a_strap_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !enRise |=> $stable(ssCode_q) && $stable(ocpStrap_q))
        else $error("strap code changed without power-on rise");
    a_ss_out: assert property (@(posedge clk_sys) disable iff (rst)
        1'b1 |=> softStartCode == $past(ssCode_q))
        else $error("soft-start output does not follow its code");
    a_ocp_delay_strap: assert property (@(posedge clk_sys) disable iff (rst)
        !(secfA_q && secfB_q) |=> ocpDelaySel == $past(ocpStrap_q[1:0]))
        else $error("strap delay not used");

    // link side: one answer pulse per taken request, and the held request never moves meanwhile
    sequence s_take;
        linkReq ##0 !linkBusy;
    endsequence
    a_ack_pulse: assert property (@(posedge clk_link) disable iff (rstLink)
        linkAck |=> !linkAck)
        else $error("answer pulse longer than one cycle");
    a_busy_hold: assert property (@(posedge clk_link) disable iff (rstLink)
        linkBusy && !linkAck |=> linkBusy && $stable(linkHold_q))
        else $error("request dropped before its answer");
    a_link_answer: assert property (@(posedge clk_link) disable iff (rstLink)
        s_take |-> ##[4:10] linkAck)
        else $error("link request not answered");
endmodule

//--- vrfs_host_model.sv
// host model: issues one register access at a time over the link request port
`timescale 1ns/1ps
module vrfs_host_model (
    input  wire logic                clk_link,
    input  wire logic                linkAck,
    input  wire logic [7:0]          linkRdata,
    output logic                     linkReq,
    output vrfs_pkg::vrfs_req_s      linkCmd
);
    initial begin
        linkReq = 1'b0;
        linkCmd = '0;
    end
    // rdata stays unknown if no answer arrives, so a hang fails its comparison
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
        int n;
        rdata = 8'hxx;
        @(posedge clk_link);
        linkReq <= 1'b1;
        linkCmd <= '{write: wr, addr: addr, wdata: wdata};
        @(posedge clk_link);
        linkReq <= 1'b0;
        // released command lines must not keep showing the last request
        linkCmd <= ~linkCmd;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_link);
            if (linkAck === 1'b1) begin
                rdata = linkRdata;
                break;
            end
        end
    endtask
endmodule

//--- vrfs_regs_tb.sv
// self-checking bench for the fault, warning, lock, strap and overcurrent register group
`timescale 1ns/1ps
module vrfs_regs_tb;
    logic                clk_sys  = 1'b0;
    logic                clk_link = 1'b0;
    logic                rst      = 1'b1;
    logic                rstLink  = 1'b1;
    logic                linkReq;
    vrfs_pkg::vrfs_req_s linkCmd;
    logic                linkAck, linkBusy, alertOut, lockActive;
    logic [7:0]          linkRdata;
    logic                powerOnPin = 1'b0;
    logic [4:0]          evt        = 5'h00;
    logic                adcValid   = 1'b0;
    logic [7:0]          adcData    = 8'h00;
    logic [3:0]          ssStrapCode  = 4'h0;
    logic [3:0]          ocpStrapCode = 4'h0;
    logic [3:0]          softStartCode;
    logic [1:0]          ocpLimitSel, ocpDelaySel;
    int                  n_errors    = 0;
    int                  checks_done = 0;

    always #5 clk_sys = ~clk_sys;
    always #16 clk_link = ~clk_link;

    vrfs_regs u_dut (.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .rstLink(rstLink),
        .linkReq(linkReq), .linkCmd(linkCmd), .linkAck(linkAck), .linkBusy(linkBusy), .linkRdata(linkRdata),
        .powerOnPin(powerOnPin), .outputLimitFlagA(evt[4]), .outputLimitFlagB(evt[3]), .phaseLimitPin(evt[2]),
        .overvoltageFlag(evt[1]), .undervoltageFlag(evt[0]), .adcValid(adcValid), .adcData(adcData),
        .ssStrapCode(ssStrapCode), .ocpStrapCode(ocpStrapCode), .alertOut(alertOut), .lockActive(lockActive),
        .softStartCode(softStartCode), .ocpLimitSel(ocpLimitSel), .ocpDelaySel(ocpDelaySel));

    vrfs_host_model u_host (.clk_link(clk_link), .linkAck(linkAck), .linkRdata(linkRdata),
        .linkReq(linkReq), .linkCmd(linkCmd));

    task automatic wrap_up();
        if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic sys(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_host.access(1'b1, a, d, r);
        sys(4);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] r;
        u_host.access(1'b0, a, 8'h00, r);
        check(r, exp);
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        rst <= 1'b1;
        rstLink <= 1'b1;
        sys(10);
        rst <= 1'b0;
        rstLink <= 1'b0;
        sys(2);
    endtask
    // power-on input toggles low then high; the rise resamples the straps
    task automatic pwr_cycle();
        @(posedge clk_sys) powerOnPin <= 1'b0;
        sys(6);
        powerOnPin <= 1'b1;
        sys(8);
    endtask
    task automatic pulse_events(input logic [4:0] e);
        @(posedge clk_sys) evt <= e;
        sys(3);
        evt <= 5'h00;
        sys(6);
    endtask
    task automatic adc(input logic [7:0] v);
        @(posedge clk_sys);
        adcValid <= 1'b1;
        adcData  <= v;
        @(posedge clk_sys) adcValid <= 1'b0;
        sys(4);
    endtask

    task automatic t_reset_map();
        rd(8'h20, 8'hff);
        rd(8'h22, 8'h00);
        rd(8'h23, 8'h00);
        rd(8'h2a, 8'h00);
        rd(8'h2c, 8'h00);
        wr(8'h26, 8'h55);
        rd(8'h26, 8'h00);
    endtask

    // every code of both overcurrent fields, soft-start boundaries 0000 and 1111
    task automatic t_straps();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            ssStrapCode  <= {2{i[1:0]}};
            ocpStrapCode <= {i[1:0], ~i[1:0]};
            pwr_cycle();
            check(8'(softStartCode), {4'h0, {2{i[1:0]}}});
            check(8'(ocpLimitSel), 8'(i[1:0]));
            check(8'(ocpDelaySel), {6'h00, ~i[1:0]});
            rd(8'h2b, {4'h0, {2{i[1:0]}}});
            rd(8'h2d, {4'h0, i[1:0], ~i[1:0]});
        end
    endtask

    task automatic t_override();
        wr(8'h2e, 8'hf6);
        rd(8'h2e, 8'h06);
        wr(8'h46, 8'h01);
        check(8'(ocpLimitSel), 8'h03);
        wr(8'h47, 8'h01);
        check(8'(ocpLimitSel), 8'h01);
        check(8'(ocpDelaySel), 8'h02);
        wr(8'h2e, 8'h05);
        check(8'(ocpLimitSel), 8'h01);
        check(8'(ocpDelaySel), 8'h01);
        rd(8'h2d, 8'h0c);
    endtask

    task automatic t_current();
        wr(8'h20, 8'h80);
        adc(8'h80);
        rd(8'h24, 8'h00);
        check(8'(alertOut), 8'h00);
        adc(8'h81);
        check(8'(alertOut), 8'h01);
        rd(8'h26, 8'h81);
        adc(8'h10);
        rd(8'h24, 8'h01);
        rd(8'h24, 8'h01);
        pwr_cycle();
        rd(8'h24, 8'h00);
        check(8'(alertOut), 8'h00);
        adc(8'hff);
        rd(8'h26, 8'hff);
    endtask

    task automatic t_faults();
        pwr_cycle();
        wr(8'h22, 8'h12);
        pulse_events(5'h1f);
        rd(8'h23, 8'h0d);
        wr(8'h22, 8'h0d);
        pwr_cycle();
        pulse_events(5'h1f);
        rd(8'h23, 8'h12);
    endtask

    task automatic t_lock();
        wr(8'h2a, 8'hff);
        check(8'(lockActive), 8'h01);
        rd(8'h2a, 8'h01);
        wr(8'h20, 8'h55);
        rd(8'h20, 8'h80);
        wr(8'h22, 8'h00);
        rd(8'h22, 8'h0d);
        wr(8'h2e, 8'h0a);
        rd(8'h2e, 8'h05);
        wr(8'h2a, 8'h00);
        rd(8'h2a, 8'h01);
        do_reset();
        rd(8'h2a, 8'h00);
        rd(8'h20, 8'hff);
    endtask

    // busy must stand from the taken request until the answer pulse has passed
    task automatic t_busy();
        logic [7:0] r;
        fork
            u_host.access(1'b0, 8'h2a, 8'h00, r);
            begin
                repeat (3) @(posedge clk_link);
                #1 check(8'(linkBusy), 8'h01);
            end
        join
        #1 check(8'(linkBusy), 8'h00);
    endtask

    // about 45 accesses of some 6 to 7 link cycles each
    initial begin
        #200000;
        n_errors++;
        $display("mismatch at %0t: run did not finish", $time);
        wrap_up();
    end

    initial begin
        do_reset();
        t_reset_map();
        t_busy();
        t_straps();
        t_override();
        t_current();
        t_faults();
        t_lock();
        wrap_up();
    end
endmodule
